// *** rtl/meter_irq_flag_logic.sv ***
// Purpose: event flags, open-drain interrupt and serial status registers
// Assumes: event inputs come from logic on sys_clk
// Notes:   serial side runs on sclk; crossings by toggles and snapshots
//
// Summary of operation
// - each latched event (bits 0, 1, 3, 5 and 7) sets its status flag high until the host clears it.
// - irq is driven low while a set flag has its mask bit at zero.
// - bit 0 sets on a 0 to 1 change of the energy register msb.
// - bit 1 sets on a line voltage sag or on loss of zero crossings.
// - in calibration mode bit 1 also marks the end of an integration.
// - bit 3 sets when a new waveform sample is written.
// - bit 4 follows the zero-crossing level and latches nothing.
// - bit 5 sets when a new temperature result is stored.
// - bit 7 sets when the energy register overflows.
// - mode bit 15 at one enters factory test mode; hosts keep it zero.
// - command bit 7 at zero reads the register, at one writes it.
`timescale 1ns/10ps
`include "meter_irq_map.svh"

module meter_irq_flag_logic (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        sclk,
   input  wire logic        sdi,
   input  wire logic        cs_n,
   input  wire logic        energy_msb,
   input  wire logic        sag_evt,
   input  wire logic        zx_loss,
   input  wire logic        cal_done,
   input  wire logic        wave_new,
   input  wire logic        zx_level,
   input  wire logic        temp_new,
   input  wire logic        energy_ovf,
   input  wire logic [7:0]  irq_mask,
   input  wire logic        irq_in,
   output logic             irq_out,
   output logic             irq_oe,
   output logic             sdo,
   output logic             sdo_oe,
   output logic [15:0]      mode_word,
   output logic             factory_test_enable,
   output logic [7:0]       flag_view
);

   // ==========================================================
   // reset release
   logic [1:0] rst_sync, next_rst_sync;
   logic       rst_core_n;

   assign next_rst_sync = {rst_sync[0], 1'b1};

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= next_rst_sync;
      end
   end

   assign rst_core_n = rst_sync[1];

   // ==========================================================
   // link end
   link_if lk ();

   serial_link_end link_end (
      .sclk (sclk),
      .sdi  (sdi),
      .cs_n (cs_n),
      .lk   (lk)
   );

   // ==========================================================
   // crossings into sys_clk: first stage read only by the second
   logic [2:0] cs_s, next_cs_s;
   logic [2:0] wr_s, next_wr_s;
   logic [2:0] clr_s, next_clr_s;
   logic       frame_start, wr_evt, clr_evt;

   always_comb begin
      next_cs_s  = cs_s;
      next_wr_s  = wr_s;
      next_clr_s = clr_s;
      if (clk_en) begin
         next_cs_s  = {cs_s[1:0], cs_n};
         next_wr_s  = {wr_s[1:0], lk.wr_tgl};
         next_clr_s = {clr_s[1:0], lk.clr_tgl};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         cs_s  <= 3'b111;
         wr_s  <= 3'b000;
         clr_s <= 3'b000;
      end else begin
         cs_s  <= next_cs_s;
         wr_s  <= next_wr_s;
         clr_s <= next_clr_s;
      end
   end

   assign frame_start = clk_en & cs_s[2] & ~cs_s[1];
   assign wr_evt      = clk_en & (wr_s[2] ^ wr_s[1]);
   assign clr_evt     = clk_en & (clr_s[2] ^ clr_s[1]);

   // ==========================================================
   // flags, mode, snapshot and interrupt
   logic [7:0]  flags, next_flags;
   logic [15:0] mode, next_mode;
   logic [7:0]  snap_flags, next_snap_flags;
   logic [15:0] snap_mode, next_snap_mode;
   logic        msb_prev, next_msb_prev;
   logic        irq_q, next_irq;
   logic        test_q, next_test;
   logic [7:0]  events;
   logic [7:0]  clr_bits;
   logic        swrst;

   always_comb begin
      events = 8'h00;
      events[`FLAG_ENERGY_HALF] = energy_msb & ~msb_prev;
      events[`FLAG_LINE_DIP]    = sag_evt | zx_loss
                                | (mode[`MODE_CAL_BIT] & cal_done);
      events[`FLAG_WAVE_SAMPLE] = wave_new;
      events[`FLAG_TEMP_READY]  = temp_new;
      events[`FLAG_ENERGY_OVF]  = energy_ovf;

      // only bits the host actually saw are cleared, so a late event
      // that missed the snapshot keeps its flag and irq stays low
      clr_bits = clr_evt ? snap_flags : 8'h00;
      swrst    = wr_evt && lk.wr_addr == `REG_MODE
                 && lk.wr_data[`MODE_SWRST_BIT];

      next_flags      = flags;
      next_mode       = mode;
      next_snap_flags = snap_flags;
      next_snap_mode  = snap_mode;
      next_msb_prev   = msb_prev;
      next_irq        = irq_q;
      next_test       = test_q;
      if (clk_en) begin
         next_msb_prev = energy_msb;
         // set wins over clear for every latched bit
         if (swrst) begin
            next_flags = events & `FLAG_LATCHED_MASK;
            next_mode  = `MODE_RESET;
         end else begin
            next_flags = ((flags & ~clr_bits) | events)
                         & `FLAG_LATCHED_MASK;
            if (wr_evt && lk.wr_addr == `REG_MODE) begin
               next_mode = lk.wr_data;
            end
         end
         next_flags[`FLAG_ZERO_CROSS] = zx_level;
         if (frame_start) begin
            next_snap_flags = flags;
            next_snap_mode  = mode;
         end
         next_irq  = |(next_flags & ~irq_mask);
         next_test = next_mode[`MODE_TEST_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         flags      <= `FLAG_RESET;
         mode       <= `MODE_RESET;
         snap_flags <= `FLAG_RESET;
         snap_mode  <= `MODE_RESET;
         msb_prev   <= 1'b0;
         irq_q      <= 1'b0;
         test_q     <= 1'b0;
      end else begin
         flags      <= next_flags;
         mode       <= next_mode;
         snap_flags <= next_snap_flags;
         snap_mode  <= next_snap_mode;
         msb_prev   <= next_msb_prev;
         irq_q      <= next_irq;
         test_q     <= next_test;
      end
   end

   // snapshot is loaded at frame start and read by the link eight
   // sclk edges later, so it is still by the time it is sampled
   assign lk.sys_rst_n  = rst_core_n;
   assign lk.snap_flags = snap_flags;
   assign lk.snap_mode  = snap_mode;

   // ==========================================================
   // outputs
   // open drain: the pin only ever pulls low, irq_in is not needed
   assign irq_out             = 1'b0;
   assign irq_oe              = irq_q;
   assign sdo                 = lk.sdo;
   assign sdo_oe              = lk.sdo_oe;
   assign mode_word           = mode;
   assign factory_test_enable = test_q;
   assign flag_view           = flags;

endmodule

// *** rtl/serial_link_end.sv ***
// Purpose: serial shifter on the link clock, command byte then data
// Assumes: host samples sdo on falling edges, device samples sdi on rising
// Notes:   one command and one transfer per chip-select frame
`timescale 1ns/10ps
`include "meter_irq_map.svh"

module serial_link_end (
   input  wire logic sclk,
   input  wire logic sdi,
   input  wire logic cs_n,
   link_if.link_side lk
);

   // ==========================================================
   // frame sequencer, cleared by the frame's own select
   meter_irq_pkg::link_state_t state, next_state;
   logic [4:0]  cnt, next_cnt;
   logic [15:0] shift, next_shift;
   logic [4:0]  addr, next_addr;
   logic        sdo_q, next_sdo;
   logic        oe_q, next_oe;
   logic        wr_fire, clr_fire;
   logic [15:0] wr_word;
   logic [7:0]  cmd;
   logic [4:0]  width;
   logic        frame_rst_n;

   // link clock stops between frames, so cs_n ends the frame
   assign frame_rst_n = lk.sys_rst_n & ~cs_n;

   always_comb begin
      next_state = state;
      next_cnt   = (cnt == 5'h1f) ? cnt : cnt + 5'h01;
      next_shift = shift;
      next_addr  = addr;
      next_sdo   = sdo_q;
      next_oe    = oe_q;
      wr_fire    = 1'b0;
      clr_fire   = 1'b0;
      wr_word    = 16'h0000;
      cmd        = {shift[6:0], sdi};
      width      = meter_irq_pkg::xfer_width(addr);
      case (state)
         meter_irq_pkg::lk_cmd: begin
            next_shift = {shift[14:0], sdi};
            if (cnt == `CMD_LAST_EDGE) begin
               next_addr = cmd[4:0];
               if (cmd[`CMD_WRITE_BIT]) begin
                  next_state = meter_irq_pkg::lk_write;
                  next_shift = 16'h0000;
               end else begin
                  next_state = meter_irq_pkg::lk_read;
                  if (cmd[4:0] == `REG_MODE) begin
                     next_shift = lk.snap_mode;
                  end else if (cmd[4:0] == `REG_FLAG_VIEW ||
                               cmd[4:0] == `REG_FLAG_VIEW_CLEAR) begin
                     next_shift = {lk.snap_flags, 8'h00};
                  end else begin
                     next_shift = 16'h0000;
                  end
                  next_sdo = next_shift[15];
                  next_oe  = 1'b1;
               end
            end
         end
         meter_irq_pkg::lk_read: begin
            next_shift = {shift[14:0], 1'b0};
            next_sdo   = shift[14];
            if (cnt == `CMD_LAST_EDGE + width) begin
               next_state = meter_irq_pkg::lk_done;
               next_oe    = 1'b0;
               clr_fire   = (addr == `REG_FLAG_VIEW_CLEAR);
            end
         end
         meter_irq_pkg::lk_write: begin
            next_shift = {shift[14:0], sdi};
            if (cnt == `CMD_LAST_EDGE + width) begin
               next_state = meter_irq_pkg::lk_done;
               wr_fire    = 1'b1;
               wr_word    = (width == `WIDTH_WORD) ? {shift[14:0], sdi}
                                                   : {8'h00, shift[6:0], sdi};
            end
         end
         meter_irq_pkg::lk_done: begin
            next_cnt = cnt;
         end
         default: begin
            next_state = meter_irq_pkg::lk_done;
         end
      endcase
   end

   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         state <= meter_irq_pkg::lk_cmd;
         cnt   <= 5'h00;
         shift <= 16'h0000;
         addr  <= 5'h00;
         sdo_q <= 1'b0;
         oe_q  <= 1'b0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         shift <= next_shift;
         addr  <= next_addr;
         sdo_q <= next_sdo;
         oe_q  <= next_oe;
      end
   end

   // ==========================================================
   // event toggles toward the core, kept across frames
   logic        wr_tgl, next_wr_tgl;
   logic        clr_tgl, next_clr_tgl;
   logic [4:0]  wr_addr, next_wr_addr;
   logic [15:0] wr_data, next_wr_data;

   always_comb begin
      next_wr_tgl  = wr_tgl ^ wr_fire;
      next_clr_tgl = clr_tgl ^ clr_fire;
      next_wr_addr = wr_fire ? addr : wr_addr;
      next_wr_data = wr_fire ? wr_word : wr_data;
   end

   always_ff @(posedge sclk or negedge lk.sys_rst_n) begin
      if (!lk.sys_rst_n) begin
         wr_tgl  <= 1'b0;
         clr_tgl <= 1'b0;
         wr_addr <= 5'h00;
         wr_data <= 16'h0000;
      end else begin
         wr_tgl  <= next_wr_tgl;
         clr_tgl <= next_clr_tgl;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
      end
   end

   assign lk.wr_tgl  = wr_tgl;
   assign lk.clr_tgl = clr_tgl;
   assign lk.wr_addr = wr_addr;
   assign lk.wr_data = wr_data;
   assign lk.sdo     = sdo_q;
   assign lk.sdo_oe  = oe_q;

endmodule

// *** shared/link_if.sv ***
// Purpose: carrier between the system-clock core and the serial link end
// Assumes: snapshot words stay still while a frame is in progress
// Notes:   toggles carry events, words are held stable across the toggle
`timescale 1ns/10ps

interface link_if;
   logic        sys_rst_n;
   logic [7:0]  snap_flags;
   logic [15:0] snap_mode;
   logic        wr_tgl;
   logic [4:0]  wr_addr;
   logic [15:0] wr_data;
   logic        clr_tgl;
   logic        sdo;
   logic        sdo_oe;

   modport core_side (
      output sys_rst_n, snap_flags, snap_mode,
      input  wr_tgl, wr_addr, wr_data, clr_tgl, sdo, sdo_oe
   );
   modport link_side (
      input  sys_rst_n, snap_flags, snap_mode,
      output wr_tgl, wr_addr, wr_data, clr_tgl, sdo, sdo_oe
   );
endinterface

// *** shared/meter_irq_map.svh ***
// Purpose: offsets, field positions and reset values of the flag logic
// Assumes: serial register space with five-bit register addresses
// Notes:   included by the package; definitions only
`ifndef METER_IRQ_MAP_SVH
`define METER_IRQ_MAP_SVH

// ==========================================================
// register addresses
`define REG_FLAG_VIEW        5'h04
`define REG_FLAG_VIEW_CLEAR  5'h05
`define REG_MODE             5'h06

// ==========================================================
// command byte
`define CMD_WRITE_BIT        7
`define CMD_LAST_EDGE        5'h07

// ==========================================================
// flag positions
`define FLAG_ENERGY_HALF     0
`define FLAG_LINE_DIP        1
`define FLAG_WAVE_SAMPLE     3
`define FLAG_ZERO_CROSS      4
`define FLAG_TEMP_READY      5
`define FLAG_ENERGY_OVF      7
`define FLAG_LATCHED_MASK    8'hab
`define FLAG_RESET           8'h00

// ==========================================================
// mode register and transfer widths
`define MODE_SWRST_BIT       6
`define MODE_CAL_BIT         7
`define MODE_TEST_BIT        15
`define MODE_RESET           16'h0000
`define WIDTH_BYTE           5'h08
`define WIDTH_WORD           5'h10

`endif

// *** shared/meter_irq_pkg.sv ***
// Purpose: types and shared decode for the flag logic
// Assumes: meter_irq_map.svh holds every number
// Notes:   used by package-qualified names only
`include "meter_irq_map.svh"

package meter_irq_pkg;

   // ==========================================================
   // link sequencer states
   typedef enum {lk_cmd, lk_read, lk_write, lk_done} link_state_t;

   // ==========================================================
   // data length in bits of a transfer to an address
   function automatic logic [4:0] xfer_width(input logic [4:0] addr);
      if (addr == `REG_MODE) begin
         xfer_width = `WIDTH_WORD;
      end else begin
         xfer_width = `WIDTH_BYTE;
      end
   endfunction

endpackage

// *** sim/host_model.sv ***
// Purpose: host microcontroller on the serial link
// Assumes: sclk idles low and stands still between frames
// Notes:   sdi set before rising edges, sdo taken on falling edges
`timescale 1ns/10ps

module host_model (
   output logic     cs_n,
   output logic     sclk,
   output logic     sdi,
   input wire logic sdo
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // ==========================================
   // one frame: command byte, then w data bits, msb first
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                       input int w, output logic [15:0] rd);
      int i;
      rd = 16'h0000;
      cs_n = 1'b0;
      // odd offset keeps sclk out of phase with sys_clk
      #23;
      for (i = 0; i < 8 + w; i++) begin
         if (i < 8) sdi = cmd[7 - i];
         else sdi = cmd[7] ? wd[w + 7 - i] : ~sdi;
         #16 sclk = 1'b1;
         #16 sclk = 1'b0;
         if (i >= 7 && i < 7 + w) rd = {rd[14:0], sdo};
      end
      #8 cs_n = 1'b1;
      sdi = ~sdi;
      #60;
   endtask
endmodule

// *** sim/meter_irq_flag_logic_properties.sv ***
// Purpose: port checks for meter_irq_flag_logic
// Assumes: core is live from the 2nd sys_clk edge after release
// Notes:   link-clock timing is judged by the bench
`timescale 1ns/10ps

module meter_irq_checker (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        clk_en,
   input wire logic        cs_n,
   input wire logic        energy_msb,
   input wire logic        sag_evt,
   input wire logic        zx_loss,
   input wire logic        cal_done,
   input wire logic        wave_new,
   input wire logic        zx_level,
   input wire logic        temp_new,
   input wire logic        energy_ovf,
   input wire logic [7:0]  irq_mask,
   input wire logic        irq_oe,
   input wire logic [15:0] mode_word,
   input wire logic        factory_test_enable,
   input wire logic [7:0]  flag_view
);
   // ==========================================
   // helpers: reset sync delay, quiet time after a frame
   logic [1:0] live_cnt;
   logic [3:0] quiet_cnt;
   logic       go;
   logic       calm;
   assign go = (live_cnt == 2'h2) && clk_en;
   // clears land a few cycles after a frame, so wait for a calm link
   assign calm = go && (quiet_cnt == 4'hf);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         live_cnt <= 2'h0;
         quiet_cnt <= 4'h0;
      end else begin
         live_cnt <= live_cnt + {1'h0, live_cnt != 2'h2};
         quiet_cnt <= cs_n ? quiet_cnt + {3'h0, quiet_cnt != 4'hf} : 4'h0;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // assertions
   wave_set_a: assert property (go && wave_new |=> flag_view[3])
      else $error("wave flag not set");
   half_set_a: assert property (
      go && $rose(energy_msb) |=> flag_view[0])
      else $error("energy half flag not set");
   dip_set_a: assert property (
      go && (sag_evt || zx_loss || (cal_done && mode_word[7]))
      |=> flag_view[1])
      else $error("line dip flag not set");
   temp_set_a: assert property (
      go && temp_new |=> flag_view[5])
      else $error("temperature flag not set");
   ovf_set_a: assert property (
      go && energy_ovf |=> flag_view[7])
      else $error("overflow flag not set");
   zx_follow_a: assert property (
      go |=> flag_view[4] == $past(zx_level))
      else $error("zero cross flag not following level");
   irq_level_a: assert property (
      calm |=> irq_oe == |(flag_view & ~$past(irq_mask)))
      else $error("irq output disagrees with flags and mask");
   flag_hold_a: assert property (
      calm && flag_view[7] |=> flag_view[7])
      else $error("flag dropped without a clear");
   // test enable is registered from the same next value as the mode word
   test_mode_a: assert property (
      go |=> factory_test_enable == mode_word[15])
      else $error("test mode does not track mode bit 15");
   cover property (go && $rose(irq_oe));
   cover property (factory_test_enable);
   cover property (flag_view[1] && mode_word[7]);
endmodule

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for meter_irq_flag_logic
// Assumes: inputs change on falling sys_clk, fixed seed
// Notes:   expected flags are rebuilt from the event stream
`timescale 1ns/10ps

module tb_top;
   logic        sys_clk, rst_n, clk_en, sclk, sdi, cs_n, energy_msb;
   logic        sag_evt, zx_loss, cal_done, wave_new, zx_level, temp_new;
   logic        energy_ovf, irq_in, irq_out, irq_oe, sdo, sdo_oe, cal_on;
   logic        factory_test_enable, sdo_line;
   logic [7:0]  irq_mask, flag_view, exp_flags;
   logic [15:0] mode_word;
   logic [31:0] r;
   int          miscompares, n_tests, i;

   initial sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;
   // open-drain line with pull-up
   assign irq_in = irq_oe ? irq_out : 1'b1;
   // serial out has a pull-up, so a missing enable reads as ones
   assign sdo_line = sdo_oe ? sdo : 1'b1;

   meter_irq_flag_logic DUT (
      .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .sclk(sclk),
      .sdi(sdi), .cs_n(cs_n), .energy_msb(energy_msb), .sag_evt(sag_evt),
      .zx_loss(zx_loss), .cal_done(cal_done), .wave_new(wave_new),
      .zx_level(zx_level), .temp_new(temp_new), .energy_ovf(energy_ovf),
      .irq_mask(irq_mask), .irq_in(irq_in), .irq_out(irq_out),
      .irq_oe(irq_oe), .sdo(sdo), .sdo_oe(sdo_oe), .mode_word(mode_word),
      .factory_test_enable(factory_test_enable), .flag_view(flag_view)
   );
   host_model host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_line));

   // ==========================================
   // checking and stimulus tasks
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // ev: {ovf, temp, wave, cal_done, zx_loss, sag}
   function automatic logic [7:0] flags_after(input logic [7:0] f,
      input logic [5:0] ev, input logic rise, input logic zx);
      logic [7:0] n;
      n = f;
      n[0] = n[0] | rise;
      n[1] = n[1] | ev[0] | ev[1] | (ev[2] & cal_on);
      n[3] = n[3] | ev[3];
      n[4] = zx;
      n[5] = n[5] | ev[4];
      n[7] = n[7] | ev[5];
      return n;
   endfunction
   task automatic step(input logic [5:0] ev, input logic msb,
                       input logic zx, input logic [7:0] m);
      exp_flags = flags_after(exp_flags, ev, msb & ~energy_msb, zx);
      {energy_ovf, temp_new, wave_new, cal_done, zx_loss, sag_evt} = ev;
      energy_msb = msb;
      zx_level = zx;
      irq_mask = m;
      @(negedge sys_clk);
      {energy_ovf, temp_new, wave_new, cal_done, zx_loss, sag_evt} = 6'h00;
      @(negedge sys_clk);
      cmp_val(flag_view, exp_flags);
      cmp_val(irq_oe, |(exp_flags & ~m));
      cmp_val(irq_in, ~|(exp_flags & ~m));
   endtask
   task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] got;
      host.xfer({3'h0, a}, 16'h0000, (a == 5'h06) ? 16 : 8, got);
      @(negedge sys_clk);
      cmp_val(got, exp);
      cmp_val(sdo_oe, 16'h0000);
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] got;
      host.xfer({3'h4, a}, d, (a == 5'h06) ? 16 : 8, got);
      @(negedge sys_clk);
   endtask
   task automatic service;
      rd_reg(5'h04, {8'h00, exp_flags});
      rd_reg(5'h05, {8'h00, exp_flags});
      exp_flags = exp_flags & 8'h10;
      cmp_val(flag_view, exp_flags);
      cmp_val(irq_oe, |(exp_flags & ~irq_mask));
   endtask
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================
   // main sequence
   initial begin
      void'($urandom(32'h2a1061ba));
      {rst_n, energy_msb, zx_level, cal_on} = 4'h0;
      {energy_ovf, temp_new, wave_new, cal_done, zx_loss, sag_evt} = 6'h00;
      clk_en = 1'b1;
      irq_mask = 8'hff;
      exp_flags = 8'h00;
      miscompares = 0;
      n_tests = 0;
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (6) @(negedge sys_clk);
      cmp_val(flag_view, 16'h0000);
      cmp_val(mode_word, 16'h0000);
      $display("test reset done");
      step(6'h3f, 1'b1, 1'b1, 8'hff);
      service();
      for (i = 0; i < 80; i++) begin
         if (i == 40) begin
            wr_reg(5'h06, 16'h0080);
            cal_on = 1'b1;
         end
         r = $urandom;
         step(r[5:0] & r[11:6], r[12], r[13], r[21:14]);
         if (i % 16 == 15) service();
      end
      $display("test random events done");
      cal_on = 1'b0;
      wr_reg(5'h06, 16'h8000);
      cmp_val(factory_test_enable, 16'h0001);
      rd_reg(5'h06, 16'h8000);
      wr_reg(5'h06, 16'h0000);
      cmp_val(factory_test_enable, 16'h0000);
      $display("test mode done");
      // a write to the status address must leave the flags alone
      wr_reg(5'h04, 16'h00ff);
      rd_reg(5'h1f, 16'h0000);
      service();
      $display("test refused access done");
      // msb left low so the edge detector sees no false rise after reset
      step(6'h21, 1'b0, 1'b1, 8'h00);
      rst_n = 1'b0;
      repeat (3) @(negedge sys_clk);
      cmp_val(flag_view, 16'h0000);
      cmp_val(irq_oe, 16'h0000);
      rst_n = 1'b1;
      repeat (6) @(negedge sys_clk);
      exp_flags = 8'h10;
      cmp_val(flag_view, {8'h00, exp_flags});
      cmp_val(irq_oe, 16'h0001);
      cmp_val(mode_word, 16'h0000);
      $display("test mid-run reset done");
      clk_en = 1'b0;
      wave_new = 1'b1;
      @(negedge sys_clk);
      {wave_new, clk_en} = 2'h1;
      @(negedge sys_clk);
      cmp_val(flag_view, {8'h00, exp_flags});
      step(6'h38, 1'b0, 1'b0, 8'h00);
      wr_reg(5'h06, 16'h0040);
      cmp_val(flag_view, 16'h0000);
      cmp_val(mode_word, 16'h0000);
      $display("test freeze and soft reset done");
      give_verdict();
   end

   initial begin
      #200000;
      miscompares++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule

bind meter_irq_flag_logic meter_irq_checker chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .cs_n(cs_n),
   .energy_msb(energy_msb), .sag_evt(sag_evt), .zx_loss(zx_loss),
   .cal_done(cal_done), .wave_new(wave_new), .zx_level(zx_level),
   .temp_new(temp_new), .energy_ovf(energy_ovf), .irq_mask(irq_mask),
   .irq_oe(irq_oe), .mode_word(mode_word),
   .factory_test_enable(factory_test_enable), .flag_view(flag_view)
);
